/* File: epa_pkg.sv */
// package: constants and types of the exception priority arbiter
`default_nettype none
package epa_pkg;
  localparam int NVEC = 48;
  localparam int NIRQ = 32;
  localparam logic [5:0] POS_STACK_TOP = 6'h00;
  localparam logic [5:0] POS_RESET     = 6'h01;
  localparam logic [5:0] POS_NMI       = 6'h02;
  localparam logic [5:0] POS_HARD      = 6'h03;
  localparam logic [5:0] POS_MEM       = 6'h04;
  localparam logic [5:0] POS_BUS       = 6'h05;
  localparam logic [5:0] POS_USAGE     = 6'h06;
  localparam logic [5:0] POS_SVC       = 6'h0b;
  localparam logic [5:0] POS_DBGMON    = 6'h0c;
  localparam logic [5:0] POS_PENDABLE_SERVICE_REQUEST    = 6'h0e;
  localparam logic [5:0] POS_TICK      = 6'h0f;
  localparam int         POS_IRQ0      = 16;
  localparam logic [3:0] RANK_RESET    = 4'h0;
  localparam logic [3:0] RANK_NMI      = 4'h1;
  localparam logic [3:0] RANK_HARD     = 4'h2;
  localparam logic [3:0] RANK_SET_BASE = 4'h3;
  localparam logic [3:0] RANK_NONE     = 4'hf;
  localparam logic [31:0] IRQ_VALID    = 32'h3ffc01ff;
  localparam logic [7:0] OFS_CTRL_STATE = 8'h00;
  localparam logic [7:0] OFS_HANDLER_EN = 8'h04;
  localparam logic [7:0] OFS_GROUP      = 8'h08;
  localparam logic [7:0] OFS_EN_SET     = 8'h0c;
  localparam logic [7:0] OFS_EN_CLR     = 8'h10;
  localparam logic [7:0] OFS_PEND_SET   = 8'h14;
  localparam logic [7:0] OFS_PEND_CLR   = 8'h18;
  localparam logic [7:0] OFS_SYS_PRIO   = 8'h1c;
  localparam logic [7:0] OFS_IRQ_PRIO0  = 8'h20;
  localparam int CS_NMI_SET    = 31;
  localparam int CS_PENDABLE_SERVICE_REQUEST_SET = 28;
  localparam int CS_PENDABLE_SERVICE_REQUEST_CLR = 27;
  localparam int CS_TICK_SET   = 26;
  localparam int CS_TICK_CLR   = 25;
  localparam int CS_ANY_PEND   = 22;
  localparam int CS_PEND_LSB   = 12;
  localparam int HE_MEM        = 16;
  localparam int HE_BUS        = 17;
  localparam int HE_USAGE      = 18;
  localparam int HE_DBGMON     = 19;
  localparam logic [2:0]  PRIO_RST  = 3'h0;
  localparam logic [3:0]  HE_RST    = 4'h0;
  localparam logic [1:0]  GROUP_RST = 2'h0;
  localparam logic [3:0]  STACK_WORDS = 4'h8;
  localparam logic [5:0] SH_POS [7] = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0e, 6'h0f};
  typedef enum logic [4:0] {
    ST_SPLOAD  = 5'b00001,
    ST_RSTVEC  = 5'b00010,
    ST_RUN     = 5'b00100,
    ST_STACK   = 5'b01000,
    ST_UNSTACK = 5'b10000
  } epa_state_e;
  typedef struct packed {
    logic mem_manage;
    logic bus_precise;
    logic bus_imprecise;
    logic usage;
    logic svc;
    logic dbg_mon;
  } epa_fault_s;
  typedef struct packed {
    logic       handler_mode;
    logic       stacking;
    logic       unstacking;
    logic       vec_fetch;
    logic       sp_load;
    logic [5:0] vec_num;
  } epa_core_s;
  localparam epa_core_s CORE_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 6'h00};
endpackage
`default_nettype wire

/* File: epa_arbiter.sv */
// exception priority arbiter with wishbone register slave
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ns
`default_nettype none
module epa_arbiter (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  input  wire epa_pkg::epa_fault_s fault_i,
  input  wire logic               dbg_halted_i,
  input  wire logic               tick_i,
  input  wire logic [31:0]        irq_i,
  input  wire logic               exc_return_i,
  input  wire logic               first_instr_i,
  output epa_pkg::epa_core_s      core_o
);
  localparam int NV = epa_pkg::NVEC;

  epa_pkg::epa_state_e st_reg, st_next;
  epa_pkg::epa_core_s  core_reg, core_next;
  logic [2:0]    prio_reg [NV];
  logic [2:0]    prio_next [NV];
  logic [NV-1:0] pend_reg, pend_next, pend_set, pend_clr;
  logic [NV-1:0] act_reg, act_next;
  logic [31:0]   en_reg, en_next;
  logic [3:0]    he_reg, he_next;
  logic [1:0]    group_reg;
  logic [3:0]    cnt_reg, cnt_next;
  logic [5:0]    cur_reg, cur_next;
  logic          reset_act_reg;
  logic          ack_reg;
  logic [31:0]   dat_reg;
  logic [4*NV-1:0] rank_f, grp_f;
  logic [NV-1:0] cand, en_mask;
  logic [31:0]   ipr_w [4];
  logic [31:0]   shp_w;

  // rank and group key of one position
  function automatic logic [7:0] epa_key(input logic [5:0] pos, input logic [2:0] p,
                                         input logic [1:0] sub);
    logic [2:0] g;
    g = p >> sub;
    if (pos == epa_pkg::POS_NMI)
      return {epa_pkg::RANK_NMI, epa_pkg::RANK_NMI};
    if (pos == epa_pkg::POS_HARD)
      return {epa_pkg::RANK_HARD, epa_pkg::RANK_HARD};
    return {{1'b0, p} + epa_pkg::RANK_SET_BASE, {1'b0, g} + epa_pkg::RANK_SET_BASE};
  endfunction

  // most urgent set bit; strict compare keeps the lower position on ties
  function automatic logic [6:0] epa_pick(input logic [NV-1:0] m, input logic [4*NV-1:0] k);
    logic [3:0] best;
    logic [6:0] r;
    best = epa_pkg::RANK_NONE;
    r = 7'h00;
    for (int i = 0; i < NV; i++) begin
      if (m[i] && (!r[6] || k[4*i+:4] < best)) begin
        best = k[4*i+:4];
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < NV; i++) begin
      rank_f[4*i+:4] = 4'(epa_key(6'(i), prio_reg[i], group_reg) >> 4);
      grp_f[4*i+:4]  = 4'(epa_key(6'(i), prio_reg[i], group_reg));
    end
  end

  always_comb begin
    en_mask = '0;
    en_mask[epa_pkg::POS_NMI]    = 1'b1;
    en_mask[epa_pkg::POS_HARD]   = 1'b1;
    en_mask[epa_pkg::POS_MEM]    = he_reg[0];
    en_mask[epa_pkg::POS_BUS]    = he_reg[1];
    en_mask[epa_pkg::POS_USAGE]  = he_reg[2];
    en_mask[epa_pkg::POS_SVC]    = 1'b1;
    en_mask[epa_pkg::POS_DBGMON] = he_reg[3];
    en_mask[epa_pkg::POS_PENDABLE_SERVICE_REQUEST] = 1'b1;
    en_mask[epa_pkg::POS_TICK]   = 1'b1;
    en_mask[NV-1:epa_pkg::POS_IRQ0] = en_reg & epa_pkg::IRQ_VALID;
  end
  assign cand = pend_reg & en_mask;

  wire [6:0] win_pick  = epa_pick(cand, rank_f);
  wire       win_found = win_pick[6];
  wire [5:0] win_vec   = win_pick[5:0];
  wire [3:0] win_grp   = grp_f[{win_vec, 2'b00}+:4];
  wire       any_act   = |act_reg;
  wire [NV-1:0] cur_1h = {{(NV-1){1'b0}}, 1'b1} << cur_reg;
  wire [6:0] ret_pick  = epa_pick(act_reg & ~cur_1h, rank_f);
  // reset level holds until first instruction
  wire [3:0] cur_grp   = reset_act_reg ? epa_pkg::RANK_RESET :
                         any_act ? grp_f[{cur_reg, 2'b00}+:4] : epa_pkg::RANK_NONE;
  wire [3:0] rem_grp   = ret_pick[6] ? grp_f[{ret_pick[5:0], 2'b00}+:4] : epa_pkg::RANK_NONE;
  wire       st_run    = (st_reg == epa_pkg::ST_RUN);
  wire       preempt   = win_found && (win_grp < cur_grp);
  wire       chain     = win_found && (win_grp < rem_grp);
  wire       ret       = st_run && exc_return_i && any_act;
  wire       take      = st_run && ((ret && chain) || (!exc_return_i && preempt));

  // bus decode
  wire [31:0] wmask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] wd     = dat_i & wmask;
  wire        wr_acc = cyc_i && stb_i && we_i && ack_reg;
  wire        wr_cs  = wr_acc && (adr_i == epa_pkg::OFS_CTRL_STATE);
  wire        wr_he  = wr_acc && (adr_i == epa_pkg::OFS_HANDLER_EN);
  wire        wr_grp = wr_acc && (adr_i == epa_pkg::OFS_GROUP);
  wire        wr_es  = wr_acc && (adr_i == epa_pkg::OFS_EN_SET);
  wire        wr_ec  = wr_acc && (adr_i == epa_pkg::OFS_EN_CLR);
  wire        wr_ps  = wr_acc && (adr_i == epa_pkg::OFS_PEND_SET);
  wire        wr_pc  = wr_acc && (adr_i == epa_pkg::OFS_PEND_CLR);
  wire        wr_shp = wr_acc && (adr_i == epa_pkg::OFS_SYS_PRIO);
  wire        ipr_hit = (adr_i[7:4] == epa_pkg::OFS_IRQ_PRIO0[7:4]);
  wire        wr_ipr = wr_acc && ipr_hit;

  // escalation checks for synchronous faults
  wire mm_ok  = he_reg[0] && (grp_f[4*epa_pkg::POS_MEM+:4] < cur_grp);
  wire bf_ok  = he_reg[1] && (grp_f[4*epa_pkg::POS_BUS+:4] < cur_grp);
  wire uf_ok  = he_reg[2] && (grp_f[4*epa_pkg::POS_USAGE+:4] < cur_grp);
  wire svc_ok = grp_f[4*epa_pkg::POS_SVC+:4] < cur_grp;
  wire esc = (fault_i.mem_manage && !mm_ok) || (fault_i.usage && !uf_ok) ||
             (fault_i.bus_precise && !bf_ok) || (fault_i.bus_imprecise && !he_reg[1]) ||
             (fault_i.svc && !svc_ok);

  always_comb begin
    pend_set = '0;
    pend_clr = '0;
    pend_set[epa_pkg::POS_NMI]    = wr_cs && wd[epa_pkg::CS_NMI_SET];
    pend_set[epa_pkg::POS_HARD]   = esc;
    pend_set[epa_pkg::POS_MEM]    = fault_i.mem_manage && mm_ok;
    pend_set[epa_pkg::POS_BUS]    = (fault_i.bus_precise && bf_ok) ||
                                    (fault_i.bus_imprecise && he_reg[1]);
    pend_set[epa_pkg::POS_USAGE]  = fault_i.usage && uf_ok;
    pend_set[epa_pkg::POS_SVC]    = fault_i.svc && svc_ok;
    pend_set[epa_pkg::POS_DBGMON] = fault_i.dbg_mon && he_reg[3] && !dbg_halted_i;
    pend_set[epa_pkg::POS_PENDABLE_SERVICE_REQUEST] = wr_cs && wd[epa_pkg::CS_PENDABLE_SERVICE_REQUEST_SET];
    pend_clr[epa_pkg::POS_PENDABLE_SERVICE_REQUEST] = wr_cs && wd[epa_pkg::CS_PENDABLE_SERVICE_REQUEST_CLR];
    pend_set[epa_pkg::POS_TICK]   = tick_i || (wr_cs && wd[epa_pkg::CS_TICK_SET]);
    pend_clr[epa_pkg::POS_TICK]   = wr_cs && wd[epa_pkg::CS_TICK_CLR];
    for (int i = 0; i < epa_pkg::NIRQ; i++) begin
      pend_set[epa_pkg::POS_IRQ0+i] = (irq_i[i] || (wr_ps && wd[i])) && epa_pkg::IRQ_VALID[i];
      pend_clr[epa_pkg::POS_IRQ0+i] = wr_pc && wd[i];
    end
    if (take)
      pend_clr[win_vec] = 1'b1;
    pend_next = (pend_reg & ~pend_clr) | pend_set;
  end

  assign en_next = ((en_reg & ~({32{wr_ec}} & wd)) | ({32{wr_es}} & wd)) & epa_pkg::IRQ_VALID;
  assign he_next = wr_he ? wd[epa_pkg::HE_DBGMON:epa_pkg::HE_MEM] : he_reg;

  always_comb begin
    for (int i = 0; i < NV; i++)
      prio_next[i] = prio_reg[i];
    for (int k = 0; k < 7; k++)
      if (wr_shp && wmask[4*k])
        prio_next[epa_pkg::SH_POS[k]] = dat_i[4*k+:3];
    for (int j = 0; j < 8; j++)
      if (wr_ipr && wmask[4*j])
        prio_next[epa_pkg::POS_IRQ0 + 8*int'(adr_i[3:2]) + j] = dat_i[4*j+:3];
  end

  // read words
  always_comb begin
    shp_w = '0;
    for (int k = 0; k < 7; k++)
      shp_w[4*k+:3] = prio_reg[epa_pkg::SH_POS[k]];
    for (int w = 0; w < 4; w++) begin
      ipr_w[w] = '0;
      for (int j = 0; j < 8; j++)
        ipr_w[w][4*j+:3] = prio_reg[epa_pkg::POS_IRQ0 + 8*w + j];
    end
  end
  wire [31:0] cs_w = (32'(pend_reg[epa_pkg::POS_NMI]) << epa_pkg::CS_NMI_SET) |
                     (32'(pend_reg[epa_pkg::POS_PENDABLE_SERVICE_REQUEST]) << epa_pkg::CS_PENDABLE_SERVICE_REQUEST_SET) |
                     (32'(pend_reg[epa_pkg::POS_TICK]) << epa_pkg::CS_TICK_SET) |
                     (32'(win_found) << epa_pkg::CS_ANY_PEND) |
                     (32'(win_vec) << epa_pkg::CS_PEND_LSB) | 32'(cur_reg);
  wire [31:0] rd_w =
    (adr_i == epa_pkg::OFS_CTRL_STATE) ? cs_w :
    (adr_i == epa_pkg::OFS_HANDLER_EN) ? (32'(he_reg) << epa_pkg::HE_MEM) :
    (adr_i == epa_pkg::OFS_GROUP)      ? 32'(group_reg) :
    (adr_i == epa_pkg::OFS_EN_SET || adr_i == epa_pkg::OFS_EN_CLR) ? en_reg :
    (adr_i == epa_pkg::OFS_PEND_SET || adr_i == epa_pkg::OFS_PEND_CLR) ?
      pend_reg[NV-1:epa_pkg::POS_IRQ0] :
    (adr_i == epa_pkg::OFS_SYS_PRIO)   ? shp_w :
    ipr_hit ? ipr_w[adr_i[3:2]] : 32'h0000_0000;

  // entry and return sequencing
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    cur_next = cur_reg;
    act_next = act_reg;
    unique case (st_reg)
      epa_pkg::ST_SPLOAD: st_next = epa_pkg::ST_RSTVEC;
      epa_pkg::ST_RSTVEC: st_next = epa_pkg::ST_RUN;
      epa_pkg::ST_RUN: begin
        if (ret) begin
          act_next = act_reg & ~cur_1h;
          cur_next = ret_pick[5:0];
          if (!chain) begin
            st_next  = epa_pkg::ST_UNSTACK;
            cnt_next = epa_pkg::STACK_WORDS - 4'h1;
          end
        end
        if (take) begin
          act_next[win_vec] = 1'b1;
          cur_next = win_vec;
          if (!ret) begin
            st_next  = epa_pkg::ST_STACK;
            cnt_next = epa_pkg::STACK_WORDS - 4'h1;
          end
        end
      end
      epa_pkg::ST_STACK, epa_pkg::ST_UNSTACK: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
          st_next = epa_pkg::ST_RUN;
      end
    endcase
  end

  always_comb begin
    core_next = core_reg;
    core_next.handler_mode = |act_next;
    core_next.stacking     = (st_next == epa_pkg::ST_STACK);
    core_next.unstacking   = (st_next == epa_pkg::ST_UNSTACK);
    core_next.sp_load      = 1'b0;
    core_next.vec_fetch    = take || (st_reg == epa_pkg::ST_SPLOAD);
    if (take)
      core_next.vec_num = win_vec;
    else if (st_reg == epa_pkg::ST_SPLOAD)
      core_next.vec_num = epa_pkg::POS_RESET;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg        <= epa_pkg::ST_SPLOAD;
      core_reg      <= epa_pkg::CORE_RST;
      pend_reg      <= '0;
      act_reg       <= '0;
      en_reg        <= '0;
      he_reg        <= epa_pkg::HE_RST;
      group_reg     <= epa_pkg::GROUP_RST;
      cnt_reg       <= 4'h0;
      cur_reg       <= 6'h00;
      reset_act_reg <= 1'b1;
      ack_reg       <= 1'b0;
      dat_reg       <= 32'h0000_0000;
    end else begin
      st_reg        <= st_next;
      core_reg      <= core_next;
      pend_reg      <= pend_next;
      act_reg       <= act_next;
      en_reg        <= en_next;
      he_reg        <= he_next;
      group_reg     <= wr_grp ? wd[1:0] : group_reg;
      cnt_reg       <= cnt_next;
      cur_reg       <= cur_next;
      reset_act_reg <= reset_act_reg && !(st_run && first_instr_i);
      ack_reg       <= cyc_i && stb_i && !ack_reg;
      dat_reg       <= rd_w;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NV; i++)
      prio_reg[i] <= rst_i ? epa_pkg::PRIO_RST : prio_next[i];
  end

  assign dat_o  = dat_reg;
  assign ack_o  = ack_reg;
  assign core_o = core_reg;

  nmi_sw_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pend_reg[epa_pkg::POS_NMI]) |-> $past(wr_cs && wd[epa_pkg::CS_NMI_SET]))
    else $error("nmi pended without software write");
  reset_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && core_o.sp_load |=> core_o.vec_fetch && core_o.vec_num == epa_pkg::POS_RESET)
    else $error("reset vector not fetched after stack top");
  stack_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !ret) |=> core_o.vec_fetch ##0 core_o.stacking[*8] ##1 !core_o.stacking)
    else $error("stacking length wrong");
  tail_chain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ret && chain) |=> core_o.vec_fetch && !core_o.stacking && !core_o.unstacking)
    else $error("tail chain restored state");
  nmi_preempt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_run && !exc_return_i && cand[epa_pkg::POS_NMI] && cur_grp > epa_pkg::RANK_NMI)
    |-> take && win_vec == epa_pkg::POS_NMI)
    else $error("nmi not taken");
  handler_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> core_o.handler_mode && core_o.vec_num == $past(win_vec))
    else $error("handler mode missing after entry");
  fault_escalate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_i.usage && !uf_ok) |=> pend_reg[epa_pkg::POS_HARD])
    else $error("fault not escalated");
  dbg_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dbg_halted_i && !pend_reg[epa_pkg::POS_DBGMON] && !wr_acc) |=>
    !pend_reg[epa_pkg::POS_DBGMON])
    else $error("debug monitor pended while halted");
  tie_break_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (win_found && win_vec > 6'd16 && cand[16]) |-> rank_f[67:64] > rank_f[{win_vec, 2'b00}+:4])
    else $error("tie not broken by position");
  reset_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_act_reg |-> !take)
    else $error("exception taken during reset level");

  preempt_c: cover property (@(posedge clk_i) disable iff (rst_i) take && any_act && !ret);
  chain_c:   cover property (@(posedge clk_i) disable iff (rst_i) ret && chain);
  nmi_c:     cover property (@(posedge clk_i) disable iff (rst_i) take && win_vec == 6'd2);
  esc_c:     cover property (@(posedge clk_i) disable iff (rst_i) esc);
endmodule // epa_arbiter
`default_nettype wire

/* File: epa_core_model.sv */
// core-side partner: reset handler start and handler return
`timescale 1ns/1ns
`default_nettype none
module epa_core_model (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire epa_pkg::epa_core_s core_i,
  input  wire logic               ret_req_i,
  output logic                    first_instr_o,
  output logic                    exc_return_o
);
  logic      sent_reg;
  wire logic boot_w;
  wire logic idle_w;

  // reset vector taken: first instruction runs next cycle
  assign boot_w = core_i.vec_fetch && (core_i.vec_num == epa_pkg::POS_RESET);
  // return only while a handler runs and no stacking is under way
  assign idle_w = core_i.handler_mode && !core_i.stacking && !core_i.unstacking
                  && !core_i.vec_fetch;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_instr_o <= 1'b0;
      exc_return_o  <= 1'b0;
      sent_reg      <= 1'b0;
    end else begin
      first_instr_o <= boot_w;
      exc_return_o  <= ret_req_i && idle_w && !sent_reg;
      sent_reg      <= ret_req_i && (sent_reg || idle_w);
    end
  end
endmodule // epa_core_model
`default_nettype wire

/* File: epa_arbiter_tb_top.sv */
// testbench of the exception priority arbiter
`timescale 1ns/1ns
`default_nettype none
module epa_arbiter_tb_top;
  logic                clk, rst, cyc, stb, we, ack, halted, tick, ret, first_instr, exc_ret;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         dat_w, dat_r, irq, rd;
  epa_pkg::epa_fault_s fault;
  epa_pkg::epa_core_s  core;
  int                  n_errors, cmp_count, n_fetch, k, m;
  logic [5:0]          evv [4];

  epa_arbiter u_epa_arbiter (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .fault_i(fault),
    .dbg_halted_i(halted), .tick_i(tick), .irq_i(irq), .exc_return_i(exc_ret),
    .first_instr_i(first_instr), .core_o(core));
  epa_core_model u_epa_core_model (.clk_i(clk), .rst_i(rst), .core_i(core), .ret_req_i(ret),
    .first_instr_o(first_instr), .exc_return_o(exc_ret));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (core.vec_fetch === 1'b1) n_fetch++;
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("bus ack", 32'(ack), 32'h1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic wait_fetch;
    int n;
    n = 0;
    while (core.vec_fetch !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("vector fetch", 32'(core.vec_fetch), 32'h1);
  endtask

  task automatic entry(input logic [5:0] v, input logic stk);
    wait_fetch();
    chk("vector", 32'(core.vec_num), 32'(v));
    chk("handler mode", 32'(core.handler_mode), 32'h1);
    chk("stacking", 32'(core.stacking), 32'(stk));
    if (stk) begin
      repeat (7) @(posedge clk);
      chk("stacking held", 32'(core.stacking), 32'h1);
      @(posedge clk);
      chk("stacking end", 32'(core.stacking), 32'h0);
    end
  endtask

  task automatic leave(input logic unstk);
    int n;
    ret <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (exc_ret !== 1'b1 && n < 100);
    ret <= 1'b0;
    @(posedge clk);
    chk("unstacking", 32'(core.unstacking), 32'(unstk));
  endtask

  task automatic pulse_ev(input int e);
    epa_pkg::epa_fault_s f;
    f = '0;
    @(posedge clk);
    case (e)
      0: f.usage = 1'b1;
      1: f.mem_manage = 1'b1;
      2: f.svc = 1'b1;
      4: f.dbg_mon = 1'b1;
      default: tick <= 1'b1;
    endcase
    fault <= f;
    @(posedge clk);
    fault <= '0;
    tick <= 1'b0;
  endtask

  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    {rst, cyc, stb, we, halted, tick, ret} = 7'h40;
    {adr, dat_w, irq} = '0;
    sel = 4'hf;
    fault = '0;
    {n_errors, cmp_count, n_fetch} = '0;
    evv = '{6'h06, 6'h04, 6'h0b, 6'h0f};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("sp load", 32'(core.sp_load), 32'h1);
    chk("sp entry", 32'(core.vec_num), 32'h0);
    wait_fetch();
    chk("reset vector", 32'(core.vec_num), 32'h1);
    repeat (4) @(posedge clk);
    rdchk(8'h1c, 32'h0, "system prio");
    rdchk(8'h20, 32'h0, "irq prio low");
    rdchk(8'h2c, 32'h0, "irq prio high");
    rdchk(8'h40, 32'h0, "unmapped");
    wb(1'b1, 8'h0c, 32'hffffffff);
    rdchk(8'h0c, 32'h3ffc01ff, "irq enables");
    irq <= 32'h400;
    m = n_fetch;
    repeat (30) @(posedge clk);
    chk("reserved line", 32'(n_fetch), 32'(m));
    irq <= 32'h1;
    entry(6'h10, 1'b1);
    irq <= 32'h0;
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b1, 8'h00, 32'h80000000);
    entry(epa_pkg::POS_NMI, 1'b1);
    leave(1'b1);
    leave(1'b1);
    wb(1'b1, 8'h14, 32'h3);
    entry(6'h10, 1'b1);
    leave(1'b0);
    entry(6'h11, 1'b0);
    leave(1'b1);
    wb(1'b1, 8'h20, 32'h23);
    wb(1'b1, 8'h14, 32'h3);
    entry(6'h11, 1'b1);
    leave(1'b0);
    entry(6'h10, 1'b0);
    leave(1'b1);
    pulse_ev(0);
    entry(epa_pkg::POS_HARD, 1'b1);
    leave(1'b1);
    wb(1'b1, 8'h04, 32'h50000);
    rdchk(8'h04, 32'h50000, "handler enables");
    for (k = 0; k < 4; k++) begin
      pulse_ev(k);
      entry(evv[k], 1'b1);
      leave(1'b1);
    end
    wb(1'b1, 8'h00, 32'h10000000);
    entry(epa_pkg::POS_PENDABLE_SERVICE_REQUEST, 1'b1);
    leave(1'b1);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b1, 8'h14, 32'h1);
    entry(6'h10, 1'b1);
    wb(1'b1, 8'h14, 32'h2);
    m = n_fetch;
    repeat (30) @(posedge clk);
    chk("same group waits", 32'(n_fetch), 32'(m));
    leave(1'b0);
    entry(6'h11, 1'b0);
    leave(1'b1);
    wb(1'b1, 8'h04, 32'hd0000);
    halted <= 1'b1;
    m = n_fetch;
    pulse_ev(4);
    repeat (20) @(posedge clk);
    chk("monitor while halted", 32'(n_fetch), 32'(m));
    halted <= 1'b0;
    pulse_ev(4);
    entry(epa_pkg::POS_DBGMON, 1'b1);
    leave(1'b1);
    report_and_stop();
  end
endmodule // epa_arbiter_tb_top
`default_nettype wire
